// ===== rtl/srr_consts.vh
// Constants for the read request and bus turnaround block.
// Assumes inclusion by bare name from the rtl folder.
//
// Contract
// R1 - Pulse bus release for one cycle automatically when a read issues.
// R2 - Release to slave state happens in the read's issue cycle itself.
// R3 - Tertiary cache hit: retake master state after its data is delivered.
// R4 - After release, regain master state when the next external request ends.
// R5 - Other request completes while read pending: release again for one cycle.
// R6 - Agent drives buses after release; needs no external request line.
// R7 - Agent may run another external request before the read response.
// R8 - Agent asserts read ready low when it can accept a read.
// R9 - Address cycle: read command, physical address 35:0, virtual 13:12 at 57:56.
// R10 - Valid out pulses exactly one cycle with the read command and address; the code holds it low in every repeated address cycle until issue.
// R11 - Stop driving the buses one cycle after the release cycle.
// R12 - Agent starts driving the buses two cycles after release, never earlier.
// R13 - Read kind flag high for instruction fetch, low for data read.
// R14 - Erroneous read response data raises a bus error exception.
// R15 - In slave state always accept a response or request, tolerate transfers.
// R16 - Each non-final response element carries valid in and mid identifier.
// R17 - Final element carries last identifier, then valid in deasserts.
// R18 - Capture data only with valid in asserted and a data identifier.
// R19 - Check bits and command parity follow data and command timing.
// R20 - Command top bit zero in address cycles, one in data cycles.
// R21 - Address cycle issues only if read ready was low two cycles before; the code checks the pin value from three cycles before.
// R22 - Keep bus drivers off throughout slave state.
`ifndef SRR_CONSTS_VH
`define SRR_CONSTS_VH
`define SRR_AD_W 64
`define SRR_ADC_W 8
`define SRR_CMD_W 9
`define SRR_PA_W 36
`define SRR_CMD_KIND_BIT 8
`define SRR_VA_LO_POS 56
`define SRR_CMD_READ 9'h000
`define SRR_ID_MID 9'h100
`define SRR_ID_LAST 9'h110
`define SRR_ID_LAST_BIT 4
`define SRR_ID_ERR_BIT 5
`define SRR_REQ_END_BIT 4
`define SRR_FIFO_DEPTH 16
`define SRR_FIFO_AW 4
`endif

// ===== rtl/srr_mem.v
// Small register file used as FIFO storage.
// Assumes a single clock; read data come out of a register.
`timescale 1ns/1ns
module srr_mem #(
  parameter W = 64,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [W-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [W-1:0] rd_data
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  // Write port and registered read port; the read register holds its
  // word until the next read, so a stalled consumer sees stable data.
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ===== rtl/srr_fifo.v
// First-in first-out buffer with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module srr_fifo #(
  parameter W = 64,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [AW:0] wp_r;
  reg [AW:0] rp_r;
  wire full;
  wire empty;
  wire push;
  wire pop;

  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign in_ready = !full;
  assign push = in_valid && !full;
  // Fetch next word when output stage is empty or being drained.
  assign pop = !empty && (!out_valid || out_ready);

  srr_mem #(.W(W), .AW(AW)) u_mem (
    .clk_sys(clk_sys),
    .wr_en(push),
    .wr_addr(wp_r[AW-1:0]),
    .wr_data(in_data),
    .rd_en(pop),
    .rd_addr(rp_r[AW-1:0]),
    .rd_data(out_data)
  );

  // Pointer and output valid update.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// ===== rtl/srr_top.v
// Read request issue and uncompelled bus turnaround on the system bus.
// Assumes the agent's pins arrive asynchronously and pass two flops.
`timescale 1ns/1ns
`include "srr_consts.vh"
module srr_top #(
  parameter AD_W = `SRR_AD_W,
  parameter ADC_W = `SRR_ADC_W,
  parameter CMD_W = `SRR_CMD_W,
  parameter FIFO_AW = `SRR_FIFO_AW
) (
  input wire clk_sys,
  input wire arst_n,
  // Core side read request.
  input wire rd_req,
  input wire [35:0] rd_paddr,
  input wire [1:0] rd_vaddr_hi,
  input wire rd_is_fetch,
  input wire [ADC_W-1:0] rd_addr_check,
  input wire rd_cmd_parity,
  output reg rd_req_taken,
  // Tertiary cache hit while the read is pending.
  input wire tc_enable,
  input wire tc_hit_done,
  // Response data toward the core.
  output wire resp_valid,
  input wire resp_ready,
  output wire [AD_W-1:0] resp_data,
  output reg bus_error_exc,
  output reg ext_req_done,
  // System bus pins.
  input wire read_accept_ready_n,
  input wire agent_valid_in_n,
  input wire [AD_W-1:0] sys_addr_data_bus_in,
  output reg [AD_W-1:0] sys_addr_data_bus_out,
  output reg sys_addr_data_bus_oe,
  input wire [CMD_W-1:0] sys_command_bus_in,
  output reg [CMD_W-1:0] sys_command_bus_out,
  output reg sys_command_bus_oe,
  input wire [ADC_W-1:0] addr_data_check_bus_in,
  output reg [ADC_W-1:0] addr_data_check_bus_out,
  input wire command_parity_bit_in,
  output reg command_parity_bit_out,
  output reg proc_valid_out_n,
  output reg bus_release_strobe_n,
  output reg read_kind_flag,
  output reg slave_state
);
  //--------------------------------------------------------------
  // Input synchronisers
  //--------------------------------------------------------------
  reg [2:0] rdy_s_r;
  reg [1:0] vin_s_r;
  reg [AD_W-1:0] ad_s1_r;
  reg [AD_W-1:0] ad_s2_r;
  reg [CMD_W-1:0] cmd_s1_r;
  reg [CMD_W-1:0] cmd_s2_r;

  // Two flops on every used pin; a third stage ages read ready by one more.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdy_s_r <= 3'h7;
      vin_s_r <= 2'h3;
      ad_s1_r <= {AD_W{1'b0}};
      ad_s2_r <= {AD_W{1'b0}};
      cmd_s1_r <= {CMD_W{1'b0}};
      cmd_s2_r <= {CMD_W{1'b0}};
    end else begin
      rdy_s_r <= {rdy_s_r[1:0], read_accept_ready_n};
      vin_s_r <= {vin_s_r[0], agent_valid_in_n};
      ad_s1_r <= sys_addr_data_bus_in;
      ad_s2_r <= ad_s1_r;
      cmd_s1_r <= sys_command_bus_in;
      cmd_s2_r <= cmd_s1_r;
    end
  end

  //--------------------------------------------------------------
  // Bus state machine
  //--------------------------------------------------------------
  localparam ST_MASTER = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_TURN = 2'h2;
  localparam ST_SLAVE = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg pend_r;
  reg pend_nxt;
  reg rerel_nxt;
  reg [AD_W-1:0] addr_word;
  wire vin;
  wire is_data;
  wire capture;
  wire last_el;
  wire req_end;
  wire fifo_in_ready;
  wire issue_nxt;

  // Validity is sampled on the same cycle pair as the data bus.
  assign vin = !vin_s_r[1];
  assign is_data = cmd_s2_r[`SRR_CMD_KIND_BIT]; // R20
  assign capture = (state_r == ST_SLAVE) && vin && is_data; // R18
  assign last_el = capture && cmd_s2_r[`SRR_ID_LAST_BIT]; // R17
  // Any other external request ends on a flagged address-kind cycle.
  assign req_end = (state_r == ST_SLAVE) && vin && !is_data &&
    cmd_s2_r[`SRR_REQ_END_BIT]; // R15
  // The coming cycle is the issue cycle when it is an address cycle and
  // ready, one stage older by then, was low; release rides in that cycle.
  assign issue_nxt = (state_nxt == ST_ADDR) && !rdy_s_r[1]; // R21

  // Address word: physical address low, virtual bits high, rest zero.
  always @* begin
    addr_word = {AD_W{1'b0}}; // R9
    addr_word[`SRR_PA_W-1:0] = rd_paddr; // R9
    addr_word[`SRR_VA_LO_POS+1:`SRR_VA_LO_POS] = rd_vaddr_hi; // R9
  end

  // Next-state logic for master, address, turnaround and slave.
  always @* begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    rerel_nxt = 1'b0;
    case (state_r)
      ST_MASTER: begin
        if (rd_req) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // Issue only when ready was low three cycles back.
        if (!rdy_s_r[2]) begin // R21
          state_nxt = ST_TURN; // R2
          pend_nxt = 1'b1;
        end
      end
      ST_TURN: begin
        state_nxt = ST_SLAVE; // R11
      end
      ST_SLAVE: begin
        if (last_el || (pend_r && tc_enable && tc_hit_done)) begin
          state_nxt = ST_MASTER; // R3
          pend_nxt = 1'b0; // R4
        end else if (req_end) begin
          if (pend_r) begin
            rerel_nxt = 1'b1; // R5
          end else begin
            state_nxt = ST_MASTER; // R4
          end
        end
      end
      default: begin
        state_nxt = ST_MASTER;
        pend_nxt = 1'b0;
      end
    endcase
  end

  // State and pin registers; every output comes from a flop.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_MASTER;
      pend_r <= 1'b0;
      rd_req_taken <= 1'b0;
      sys_addr_data_bus_out <= {AD_W{1'b0}};
      sys_addr_data_bus_oe <= 1'b0;
      sys_command_bus_out <= {CMD_W{1'b0}};
      sys_command_bus_oe <= 1'b0;
      addr_data_check_bus_out <= {ADC_W{1'b0}};
      command_parity_bit_out <= 1'b0;
      proc_valid_out_n <= 1'b1;
      bus_release_strobe_n <= 1'b1;
      read_kind_flag <= 1'b0;
      slave_state <= 1'b0;
      bus_error_exc <= 1'b0;
      ext_req_done <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      rd_req_taken <= issue_nxt; // R21
      ext_req_done <= req_end;
      // Error flag bit in a data identifier raises a bus error.
      bus_error_exc <= capture && cmd_s2_r[`SRR_ID_ERR_BIT]; // R14
      slave_state <= (state_nxt == ST_SLAVE);
      // Release pulses in the issue cycle itself and again on re-release.
      bus_release_strobe_n <= !(issue_nxt || rerel_nxt); // R1 R2
      if (state_nxt == ST_ADDR) begin
        // Repeat the address cycle each cycle until it issues.
        sys_addr_data_bus_out <= addr_word; // R9
        sys_command_bus_out <= `SRR_CMD_READ; // R20
        addr_data_check_bus_out <= rd_addr_check; // R19
        command_parity_bit_out <= rd_cmd_parity; // R19
        sys_addr_data_bus_oe <= 1'b1;
        sys_command_bus_oe <= 1'b1;
        read_kind_flag <= rd_is_fetch; // R13
        proc_valid_out_n <= 1'b0; // R10
      end else begin
        proc_valid_out_n <= 1'b1; // R10
        read_kind_flag <= 1'b0;
        // Drivers drop the cycle after release and stay off in slave state.
        sys_addr_data_bus_oe <= 1'b0; // R11 R22
        sys_command_bus_oe <= 1'b0; // R11 R22
      end
    end
  end

  //--------------------------------------------------------------
  // Response data buffer
  //--------------------------------------------------------------
  // Captured words queue toward the core. The agent cannot be stalled
  // mid-response, so a word that meets a full queue is dropped.
  srr_fifo #(.W(AD_W), .AW(FIFO_AW)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(capture), // R18
    .in_ready(fifo_in_ready),
    .in_data(ad_s2_r),
    .out_valid(resp_valid),
    .out_ready(resp_ready),
    .out_data(resp_data)
  );

endmodule

// ===== verif/srr_props.sv
// Checker on the read issue and turnaround ports of srr_top.
// Assumes it is bound into srr_top and sees its ports only.
`timescale 1ns/1ns
module srr_props (
  input wire clk_sys,
  input wire arst_n,
  input wire rd_req_taken,
  input wire [35:0] rd_paddr,
  input wire [1:0] rd_vaddr_hi,
  input wire rd_is_fetch,
  input wire [7:0] rd_addr_check,
  input wire rd_cmd_parity,
  input wire bus_error_exc,
  input wire ext_req_done,
  input wire [63:0] sys_addr_data_bus_out,
  input wire sys_addr_data_bus_oe,
  input wire [8:0] sys_command_bus_out,
  input wire sys_command_bus_oe,
  input wire [7:0] addr_data_check_bus_out,
  input wire command_parity_bit_out,
  input wire proc_valid_out_n,
  input wire bus_release_strobe_n,
  input wire read_kind_flag,
  input wire slave_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Address cycles and any drive onto the shared buses.
  wire adr = !proc_valid_out_n;
  wire oe = sys_addr_data_bus_oe || sys_command_bus_oe;
  rel_pulse_a: assert property (
    $fell(bus_release_strobe_n) |=> bus_release_strobe_n)
    else $error("release strobe too long");
  issue_rel_a: assert property (
    rd_req_taken |-> !bus_release_strobe_n && !proc_valid_out_n)
    else $error("no release in issue cycle");
  valid_once_a: assert property (
    rd_req_taken |=> proc_valid_out_n)
    else $error("valid out held past issue");
  addr_cmd_a: assert property (
    adr |-> sys_command_bus_out == 9'h000 && sys_addr_data_bus_oe &&
      sys_command_bus_oe && !slave_state)
    else $error("address cycle command wrong");
  addr_val_a: assert property (
    adr |-> sys_addr_data_bus_out ==
      {6'h00, rd_vaddr_hi, 20'h00000, rd_paddr})
    else $error("address cycle address wrong");
  kind_flag_a: assert property (
    adr |-> read_kind_flag == rd_is_fetch)
    else $error("read kind flag wrong");
  check_par_a: assert property (
    adr |-> addr_data_check_bus_out == rd_addr_check &&
      command_parity_bit_out == rd_cmd_parity)
    else $error("check bits out of step");
  drive_drop_a: assert property (
    !bus_release_strobe_n |=> !oe)
    else $error("bus driven after release");
  slave_quiet_a: assert property (
    slave_state |-> !oe)
    else $error("bus driven in slave state");
  cover property (bus_error_exc);
  cover property (ext_req_done);
  cover property ($fell(slave_state));
  cover property (!bus_release_strobe_n && slave_state);
endmodule
bind srr_top srr_props i_srr_props (.*);

// ===== verif/srr_agent.sv
// Behavioural system agent facing the bus pins of srr_top.
// Assumes the bench resolves the shared buses from both drivers.
`timescale 1ns/1ns
module srr_agent (
  input wire clk_sys,
  input wire bus_release_strobe_n,
  input wire hold_ready,
  input wire silent,
  input wire pre_ext,
  input wire [4:0] n_words,
  input wire [4:0] err_at,
  input wire [31:0] base,
  output wire read_accept_ready_n,
  output reg agent_valid_in_n,
  output reg [63:0] ad,
  output reg [8:0] cmd,
  output reg busy
);
  integer k;
  // Ready is low whenever the bench lets reads in.
  assign read_accept_ready_n = hold_ready;
  // Keeps off the bus for one to three cycles after a release.
  task gap;
    begin
      repeat (1 + $urandom % 3) @(posedge clk_sys);
      #1;
    end
  endtask
  // Drives one valid cycle of the given contents.
  task put(input [63:0] d, input [8:0] c);
    begin
      agent_valid_in_n = 1'b0;
      ad = d;
      cmd = c;
      @(posedge clk_sys);
      #1;
    end
  endtask
  // Unless silent, answers each release with an optional request, then the data.
  initial begin
    {agent_valid_in_n, busy, ad, cmd} = {1'b1, 74'h0};
    forever begin
      @(posedge clk_sys);
      if (!bus_release_strobe_n && !silent) begin
        busy = 1'b1;
        gap;
        if (pre_ext) begin
          put(~ad, 9'h010);
          agent_valid_in_n = 1'b1;
          @(posedge clk_sys);
          while (bus_release_strobe_n) @(posedge clk_sys);
          gap;
        end
        for (k = 0; k < n_words; k = k + 1) begin
          if (k > 0 && $urandom % 2) begin
            agent_valid_in_n = 1'b1;
            ad = ~ad;
            @(posedge clk_sys);
            #1;
          end
          put({base, k}, (k == n_words - 1 ? 9'h110 : 9'h100) |
            (k == err_at ? 9'h020 : 9'h000));
        end
        agent_valid_in_n = 1'b1;
        busy = 1'b0;
      end
      #1 ad = ~ad;
    end
  end
endmodule

// ===== verif/test_srr_top.sv
// Self-checking bench for srr_top with a behavioural agent.
// Assumes the design, its constants header, checker and agent model.
`timescale 1ns/1ns
`include "srr_consts.vh"
module test_srr_top;
  reg clk_sys, arst_n, rd_req, rd_is_fetch, rd_cmd_parity, tc_enable;
  reg [35:0] rd_paddr;
  reg [1:0] rd_vaddr_hi;
  reg [7:0] rd_addr_check;
  reg tc_hit_done, resp_ready, hold_ready, silent, pre_ext, hold_rsp, skip;
  reg [4:0] n_words, err_at;
  reg [31:0] base;
  reg [63:0] r64;
  reg [63:0] exp_q [$];
  wire [63:0] resp_data, sys_addr_data_bus_out, sys_addr_data_bus_in, ag_ad;
  wire [8:0] sys_command_bus_out, sys_command_bus_in, ag_cmd;
  wire [7:0] addr_data_check_bus_out, addr_data_check_bus_in;
  wire resp_valid, bus_error_exc, ext_req_done, rd_req_taken, slave_state;
  wire sys_addr_data_bus_oe, sys_command_bus_oe, command_parity_bit_out;
  wire command_parity_bit_in, read_accept_ready_n, agent_valid_in_n;
  wire proc_valid_out_n, bus_release_strobe_n, read_kind_flag, busy;
  integer err_total, n_tests, n_err, n_ext, n_tk, cyc, i, j, t, e0, x0, tk0;
  srr_top i_srr_top (.*);
  srr_agent i_srr_agent (.*, .ad(ag_ad), .cmd(ag_cmd));
  // Each shared line carries whichever side drives it.
  assign sys_addr_data_bus_in = sys_addr_data_bus_oe ?
    sys_addr_data_bus_out : ag_ad;
  assign sys_command_bus_in = sys_command_bus_oe ? sys_command_bus_out : ag_cmd;
  assign addr_data_check_bus_in = sys_addr_data_bus_oe ?
    addr_data_check_bus_out : ag_ad[7:0];
  assign command_parity_bit_in = sys_command_bus_oe ?
    command_parity_bit_out : ^ag_cmd;
  // Clock at 100 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task summarize;
    begin
      if (err_total == 0 && n_tests > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [8*12-1:0] nm, input [63:0] e, input [63:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        $display("Error %0s exp %h got %h", nm, e, g);
        err_total = err_total + 1;
      end
    end
  endtask
  function [63:0] word_of(input [31:0] b, input integer k);
    word_of = {b, k};
  endfunction
  // Counts design pulses and cuts a hang short.
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    n_err = n_err + (bus_error_exc === 1'b1);
    n_ext = n_ext + (ext_req_done === 1'b1);
    n_tk = n_tk + (rd_req_taken === 1'b1);
    if (cyc == 20000) begin
      err_total = err_total + 1;
      summarize;
    end
  end
  // Pulls responses at random and compares them in order.
  always @(posedge clk_sys) begin
    if (resp_valid === 1'b1 && resp_ready && !skip)
      chk("resp_data", exp_q.pop_front(), resp_data);
    #1 resp_ready = !hold_rsp && ($urandom % 4 != 0);
  end
  // One read: optional hold-off, issue, optional cache hit, completion checks.
  task rd(input f, input [4:0] nw, input [4:0] ea, input pe, input hr,
    input tc);
    begin
      r64 = {$urandom, $urandom};
      {rd_cmd_parity, rd_addr_check, rd_vaddr_hi, rd_paddr} = r64[46:0];
      {rd_is_fetch, base, n_words, err_at} = {f, $urandom, nw, ea};
      {pre_ext, silent, tc_enable, hold_ready} = {pe, tc, tc, hr};
      // The queue keeps its 16 words plus the one in its output stage.
      for (i = 0; i < nw && i < `SRR_FIFO_DEPTH + 1 && !skip; i = i + 1)
        exp_q.push_back(word_of(base, i));
      {e0, x0, tk0, t} = {n_err, n_ext, n_tk, 32'h0};
      repeat (4) @(posedge clk_sys);
      #1 rd_req = 1'b1;
      if (hr) begin
        repeat (6) @(posedge clk_sys);
        #1 chk("early_issue", tk0, n_tk);
        chk("taken_cnt", 0, rd_req_taken);
        chk("addr_repeat", 0, proc_valid_out_n);
        hold_ready = 1'b0;
      end
      while (rd_req_taken !== 1'b1 && t < 100) begin
        @(posedge clk_sys);
        #1 t = t + 1;
      end
      rd_req = 1'b0;
      if (tc) begin
        repeat (3) @(posedge clk_sys);
        #1 tc_hit_done = 1'b1;
        @(posedge clk_sys);
        #1 tc_hit_done = 1'b0;
      end
      t = 0;
      while ((busy || slave_state !== 1'b0 || t < 6) && t < 400) begin
        @(posedge clk_sys);
        #1 t = t + 1;
      end
      chk("slave_state", 0, slave_state);
      chk("bus_error", ea < nw, n_err - e0);
      chk("ext_done", pe, n_ext - x0);
    end
  endtask
  initial begin
    {arst_n, rd_req, tc_enable, tc_hit_done, resp_ready, hold_ready} = 0;
    {silent, pre_ext, hold_rsp, skip, rd_is_fetch, rd_cmd_parity} = 0;
    {rd_paddr, rd_vaddr_hi, rd_addr_check, n_words, err_at, base} = 0;
    {err_total, n_tests, n_err, n_ext, n_tk, cyc} = 0;
    r64 = $urandom(93);
    repeat (12) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    rd(1, 1, 31, 0, 0, 0);
    rd(0, 4, 31, 1, 1, 0);
    rd(0, 0, 31, 0, 0, 1);
    skip = 1'b1;
    rd(0, 3, 1, 0, 0, 0);
    repeat (30) @(posedge clk_sys);
    #1 skip = 1'b0;
    for (j = 0; j < 6; j = j + 1)
      rd($urandom % 2, 1 + $urandom % 4, 31, $urandom % 2, 0, 0);
    repeat (30) @(posedge clk_sys);
    #1 hold_rsp = 1'b1;
    rd(0, 18, 31, 0, 0, 0);
    chk("fifo_full", 1, resp_valid);
    hold_rsp = 1'b0;
    repeat (40) @(posedge clk_sys);
    #1 chk("fifo_left", 0, exp_q.size());
    summarize;
  end
endmodule
